// ---- src/csd_pkg.sv ----
package csd_pkg;

    // Register word byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_CSD0 = 8'h00;
    localparam logic [7:0] ADDR_CSD1 = 8'h04;
    localparam logic [7:0] ADDR_CSD2 = 8'h08;
    localparam logic [7:0] ADDR_CSD3 = 8'h0C;
    localparam logic [7:0] ADDR_PROG = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_SHIFT = 8'h1C;

    // Field positions within the 128-bit word.
    localparam int LAYOUT_HI = 127;
    localparam int CLASS_LO = 84;
    localparam int SIZE_LO = 48;
    localparam int COPY_POS = 14;
    localparam int PERM_POS = 13;
    localparam int TEMP_POS = 12;
    localparam int CRC_LO = 1;

    // Fixed field values, and reset values of the size and checksum.
    localparam logic [1:0] LAYOUT_VERSION = 2'h1;
    localparam logic [7:0] READ_ACCESS_TIME = 8'h0E;
    localparam logic [7:0] READ_ACCESS_CYCLES = 8'h00;
    localparam logic [7:0] RATE_DEFAULT = 8'h32;
    localparam logic [7:0] RATE_HIGH_SPEED = 8'h5A;
    localparam logic [11:0] COMMAND_CLASS_SET = 12'h5B5;
    localparam logic [3:0] BLOCK_LENGTH = 4'h9;
    localparam logic [6:0] SECTOR_SIZE = 7'h7F;
    localparam logic [6:0] PROTECT_GROUP_SIZE = 7'h00;
    localparam logic [2:0] WRITE_SPEED_FACTOR = 3'h2;
    localparam logic [21:0] SIZE_DEFAULT = 22'h00_1DFF;
    localparam logic [6:0] CRC_DEFAULT = 7'h00;

    // Programmable field reset values.
    localparam logic COPY_RESET = 1'b0;
    localparam logic PERM_RESET = 1'b0;
    localparam logic TEMP_RESET = 1'b0;

    // Control and status bit positions.
    localparam int CTRL_HS = 0;
    localparam int CTRL_DSR = 1;
    localparam int CTRL_SHIFT = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_BLOCKED = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SHIFT_BITS = 128;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_RUN = 2'b10
    } shift_state_t;

endpackage

// ---- src/csd_assemble.sv ----
`timescale 1ns/1ps
`default_nettype none
module csd_assemble
    import csd_pkg::*;
(
    // Variable fields
    input wire logic high_speed,
    input wire logic dsr_present,
    input wire logic [21:0] dev_size,
    input wire logic copy_flag,
    input wire logic perm_lock,
    input wire logic temp_lock,
    input wire logic [6:0] crc,
    // Assembled word
    output logic [127:0] word
);
    // The upper six bits of the size are forced to zero.
    wire [21:0] size_clamped = {6'h00, dev_size[15:0]}; // RULE12
    wire [7:0] rate = high_speed ? RATE_HIGH_SPEED : RATE_DEFAULT; // RULE5

    assign word = {
        LAYOUT_VERSION, 6'h00,                   // RULE1
        READ_ACCESS_TIME, READ_ACCESS_CYCLES,    // RULE2
        rate,                                    // RULE6
        COMMAND_CLASS_SET,                       // RULE7
        BLOCK_LENGTH,                            // RULE8
        1'b0, 1'b0, 1'b0,                        // RULE9 RULE10
        dsr_present, 6'h00,                      // RULE11
        size_clamped, 1'b0,
        1'b1,                                    // RULE13
        SECTOR_SIZE,                             // RULE14
        PROTECT_GROUP_SIZE, 1'b0, 2'h0,          // RULE15
        WRITE_SPEED_FACTOR,                      // RULE4
        BLOCK_LENGTH, 1'b0, 5'h00,               // RULE8 RULE9
        1'b0,                                    // RULE18
        copy_flag, perm_lock, temp_lock,         // RULE16 RULE17
        2'h0, 2'h0,                              // RULE18
        crc, 1'b1                                // RULE22
    };
endmodule
`default_nettype wire

// ---- src/csd_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
module csd_shifter
    import csd_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Load request
    input wire logic start,
    input wire logic [127:0] word,
    // Serial output
    output logic serial_out,
    output logic busy
);
    shift_state_t state;
    logic [127:0] shreg;
    logic [7:0] count;
    wire last = (count == 8'(SHIFT_BITS - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SH_IDLE;
            shreg <= '0;
            count <= '0;
            serial_out <= 1'b1;
        end else begin
            unique case (state)
                SH_IDLE: begin
                    if (start) begin
                        shreg <= {word[126:0], 1'b1};
                        serial_out <= word[127]; // RULE22
                        count <= '0;
                        state <= SH_RUN;
                    end
                end
                SH_RUN: begin
                    if (last) begin
                        state <= SH_IDLE;
                        serial_out <= 1'b1;
                    end else begin
                        serial_out <= shreg[127]; // RULE22
                        shreg <= {shreg[126:0], 1'b1};
                        count <= count + 8'h01;
                    end
                end
            endcase
        end
    end

    assign busy = (state == SH_RUN);
endmodule
`default_nettype wire

// ---- src/csd_register.sv ----
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Top two bits carry layout version 01b.
// RULE2 - Read access time reads 0Eh, access cycles read 00h.
// RULE3 - Host uses fixed timeouts, not access-time fields.
// RULE4 - Write speed factor fixed at 010b; host uses 250 ms write timeout.
// RULE5 - Rate byte: unit in bits 2:0, multiplier in 6:3.
// RULE6 - Rate 032h default timing, 05Ah high speed, back on reset.
// RULE7 - Command class field bits 95:84 holds the fixed support pattern.
// RULE8 - Read and write block lengths both 9h, 512 bytes.
// RULE9 - Partial read and partial write flags are zero.
// RULE10 - Write and read misalignment flags are zero.
// RULE11 - Driver stage flag set only if a driver register exists.
// RULE12 - 22-bit size at 69:48, upper six bits zero.
// RULE13 - Single block erase flag reads one.
// RULE14 - Erase sector size reads 7Fh.
// RULE15 - Protect group size and enable read zero.
// RULE16 - Copy flag bit 14 may be programmed once.
// RULE17 - Permanent lock once-writable, temporary lock rewritable, rest read-only; here the size also takes writes to CSD word one.
// RULE18 - Format group bit and format field held at zero.
// RULE19 - Permanent lock blocks all writes and erases.
// RULE20 - Temporary lock blocks writes and erases, resets to zero.
// RULE21 - Host recomputes checksum after changing programmable fields.
// RULE22 - Register shifted out MSB first, last bit always one.
module csd_register
    import csd_pkg::*;
#(
    parameter logic DSR_FITTED = 1'b0
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Card-side controls from the command decoder
    input wire logic mode_reset,
    input wire logic write_request,
    // Card-side results
    output logic write_blocked,
    output logic serial_out,
    output logic high_speed
);
    logic copy_flag;
    logic perm_lock;
    logic temp_lock;
    logic [6:0] crc;
    logic [21:0] dev_size;
    logic shift_start;
    logic shift_busy;
    logic [127:0] word;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic shifter_out;

    csd_assemble u_assemble (
        .high_speed(high_speed),
        .dsr_present(DSR_FITTED), // RULE11
        .dev_size(dev_size),
        .copy_flag(copy_flag),
        .perm_lock(perm_lock),
        .temp_lock(temp_lock),
        .crc(crc),
        .word(word)
    );

    csd_shifter u_shifter (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(shift_start),
        .word(word),
        .serial_out(shifter_out),
        .busy(shift_busy)
    );

    // Write channel: address and data are taken independently.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire sel_prog = (aw_addr == ADDR_PROG);
    wire sel_ctrl = (aw_addr == ADDR_CTRL);
    wire sel_size = (aw_addr == ADDR_CSD1);
    wire wr_ok = sel_prog || sel_ctrl || sel_size;
    wire lane0 = w_strb[0];

    // One-time bits only move from zero to one.
    wire next_copy = copy_flag | (w_data[COPY_POS] & lane0); // RULE16
    wire next_perm = perm_lock | (w_data[PERM_POS] & lane0); // RULE17
    wire next_temp = w_data[TEMP_POS]; // RULE17

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Programmable fields; the checksum stays whatever the host wrote.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            copy_flag <= COPY_RESET;
            perm_lock <= PERM_RESET;
            temp_lock <= TEMP_RESET; // RULE20
            crc <= CRC_DEFAULT; // RULE21
        end else if (do_write && sel_prog && lane0) begin
            copy_flag <= next_copy;
            perm_lock <= next_perm;
            temp_lock <= next_temp;
            crc <= w_data[CRC_LO +: 7];
        end
    end

    // Device size is set by factory software through CSD word one, on every write with both upper byte lanes enabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_size <= SIZE_DEFAULT;
        end else if (do_write && sel_size && (&w_strb[3:2])) begin
            dev_size <= {6'h00, w_data[31:16]}; // RULE12
        end
    end

    // Timing mode drops to default on a mode reset command.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_speed <= 1'b0;
        end else if (mode_reset) begin
            high_speed <= 1'b0; // RULE6
        end else if (do_write && sel_ctrl && lane0) begin
            high_speed <= w_data[CTRL_HS]; // RULE6
        end
    end

    assign shift_start = do_write && sel_ctrl && lane0 &&
        w_data[CTRL_SHIFT] && !shift_busy;

    // Either lock refuses writes and erases on the card side.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_blocked <= 1'b0;
            serial_out <= 1'b1;
        end else begin
            write_blocked <= write_request && (perm_lock || temp_lock); // RULE19 RULE20
            serial_out <= shifter_out;
        end
    end

    // Read channel answers one cycle after the address is taken.
    wire ar_take = s_axi_arvalid && s_axi_arready;
    logic [31:0] rd_mux;
    logic rd_ok;

    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CSD0: rd_mux = word[31:0];
            ADDR_CSD1: rd_mux = word[63:32];
            ADDR_CSD2: rd_mux = word[95:64];
            ADDR_CSD3: rd_mux = word[127:96];
            ADDR_PROG: rd_mux = word[31:0];
            ADDR_CTRL: rd_mux = {30'h0, DSR_FITTED, high_speed};
            ADDR_STAT: rd_mux = {30'h0, perm_lock | temp_lock, shift_busy};
            ADDR_SHIFT: rd_mux = {31'h0, serial_out};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/csd_register_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module csd_register_checker
    import csd_pkg::*;
#(
    parameter logic DSR_FITTED = 1'b0
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Card side
    input wire logic mode_reset,
    input wire logic write_request,
    input wire logic write_blocked,
    input wire logic high_speed
);
    logic [7:0] last_ar;
    logic ok;
    assign ok = s_axi_rvalid && s_axi_rresp == RESP_OKAY;
    // The read address is kept so that data can be judged by its word.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_ar <= 8'hFF;
        end else if (s_axi_arvalid && s_axi_arready) begin
            last_ar <= s_axi_araddr;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_top_word: assert property (
        ok && last_ar == ADDR_CSD3 |-> s_axi_rdata[31:8] == 24'h400E00)
        else $error("top word fixed bits wrong");
    chk_rate_mode: assert property (
        ok && last_ar == ADDR_CSD3 |->
        s_axi_rdata[7:0] == (high_speed ? 8'h5A : 8'h32))
        else $error("rate code does not follow timing mode");
    chk_class_word: assert property (
        ok && last_ar == ADDR_CSD2 |->
        s_axi_rdata == {12'h5B5, 4'h9, 3'h0, DSR_FITTED, 12'h000})
        else $error("class word wrong");
    chk_erase_word: assert property (
        ok && last_ar == ADDR_CSD1 |-> s_axi_rdata[15:0] == 16'h7F80)
        else $error("erase fields wrong");
    chk_low_word: assert property (
        ok && last_ar == ADDR_CSD0 |-> s_axi_rdata[31:15] == 17'h01480
        && s_axi_rdata[11:8] == 4'h0 && s_axi_rdata[0])
        else $error("low word fixed bits wrong");
    chk_unmapped_err: assert property (
        s_axi_rvalid && last_ar > 8'h1F |->
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_mode_default: assert property (
        mode_reset |=> !high_speed) else $error("timing mode kept");
    chk_block_cause: assert property (
        write_blocked |-> $past(write_request))
        else $error("block without request");
    chk_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    cover property (ok && last_ar == ADDR_CSD0);
    cover property (write_blocked);
    cover property (ok && high_speed && last_ar == ADDR_CSD3);
endmodule
bind csd_register csd_register_checker #(.DSR_FITTED(DSR_FITTED)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mode_reset(mode_reset), .write_request(write_request),
    .write_blocked(write_blocked), .high_speed(high_speed));
`default_nettype wire

// ---- testbench/csd_host_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
module csd_host_rx
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Serial line and capture
    input wire logic serial_out,
    input wire logic arm,
    output logic [127:0] word,
    output logic done
);
    logic run;
    logic [7:0] cnt;
    // The first low bit starts a frame, since the top bit is always 0.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            cnt <= 8'h00;
            done <= 1'b0;
            word <= '0;
        end else begin
            done <= 1'b0;
            if (run || (arm && !serial_out)) begin
                word <= {word[126:0], serial_out};
                cnt <= run ? cnt + 8'h01 : 8'h01;
                run <= !(run && cnt == 8'h7F);
                done <= run && cnt == 8'h7F;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/card_specific_data_v2_register_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module card_specific_data_v2_register_test
    import csd_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic mode_reset, write_request, arm, hs, cp, pm, tp, done;
    logic awready, wready, bvalid, arready, rvalid;
    logic write_blocked, serial_out, high_speed;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [127:0] rx_word;
    logic [6:0] crc;
    logic [21:0] sz;
    logic [33:0] re;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [127:0] sq[$];
    int fail_count, checks_done;
    csd_register #(.DSR_FITTED(1'b1)) i_csd_register (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mode_reset(mode_reset),
        .write_request(write_request), .write_blocked(write_blocked),
        .serial_out(serial_out), .high_speed(high_speed));
    csd_host_rx i_csd_host_rx (.aclk(aclk), .aresetn(aresetn),
        .serial_out(serial_out), .arm(arm), .word(rx_word), .done(done));
    function automatic logic [127:0] ew();
        ew = {8'h40, 8'h0E, 8'h00, (hs ? 8'h5A : 8'h32), 12'h5B5, 4'h9,
            4'h1, 6'h0, sz, 2'h1, 7'h7F, 7'h0, 3'h0, 3'h2, 4'h9, 7'h0,
            cp, pm, tp, 4'h0, crc, 1'b1};
    endfunction
    task automatic check_val(input string n, input logic [127:0] e,
        input logic [127:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] er);
        bq.push_back(er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        rq.push_back({er, ed});
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic rdall();
        logic [127:0] w;
        w = ew();
        for (int i = 0; i < 4; i++)
            rd(8'(i * 4), w[i * 32 +: 32], RESP_OKAY);
    endtask
    task automatic blk(input logic e);
        @(posedge aclk);
        write_request <= 1'b1;
        @(posedge aclk);
        write_request <= 1'b0;
        @(negedge aclk);
        check_val("write_blocked", e, write_blocked);
    endtask
    task automatic prog(input logic c, input logic p, input logic t);
        logic [6:0] r;
        r = 7'($urandom);
        wr(ADDR_PROG, {17'h0, c, p, t, 4'h0, r, 1'b0}, RESP_OKAY);
        {cp, pm, tp, crc} = {cp | c, pm | p, t, r};
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Results are judged apart from the driver, oldest note first.
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            re = rq.pop_front();
            check_val("rdata", re[31:0], rdata);
            check_val("rresp", re[33:32], rresp);
        end
        if (bvalid && bready)
            check_val("bresp", bq.pop_front(), bresp);
        if (done)
            check_val("serial word", sq.pop_front(), rx_word);
    end
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        #1_000_000;
        fail_count++;
        results();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {mode_reset, write_request, arm, hs, cp, pm, tp} = '0;
        {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
        crc = CRC_DEFAULT;
        sz = SIZE_DEFAULT;
        void'($urandom(32'hBEDD));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rdall();
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(ADDR_CSD0, 32'hFFFF_FFFF, RESP_SLVERR);
        d = $urandom;
        wr(ADDR_CSD1, d, RESP_OKAY);
        sz = {6'h0, d[31:16]};
        rdall();
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        hs = 1'b1;
        rd(ADDR_CTRL, 32'h3, RESP_OKAY);
        rdall();
        @(posedge aclk);
        mode_reset <= 1'b1;
        @(posedge aclk);
        mode_reset <= 1'b0;
        hs = 1'b0;
        rdall();
        blk(1'b0);
        prog(1'b0, 1'b0, 1'b1);
        blk(1'b1);
        rdall();
        prog(1'b0, 1'b0, 1'b0);
        blk(1'b0);
        prog(1'b1, 1'b1, 1'b0);
        blk(1'b1);
        prog(1'b0, 1'b0, 1'b0);
        rdall();
        rd(ADDR_STAT, 32'h2, RESP_OKAY);
        blk(1'b1);
        // The mode is set first, since the frame latches the word at start.
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        hs = 1'b1;
        @(posedge aclk);
        arm <= 1'b1;
        sq.push_back(ew());
        wr(ADDR_CTRL, 32'h5, RESP_OKAY);
        for (int i = 0; i < 300 && !done; i++)
            @(posedge aclk);
        repeat (3) @(posedge aclk);
        check_val("pending frames", 0, sq.size());
        check_val("serial idle", 1'b1, serial_out);
        results();
    end
endmodule
`default_nettype wire
